// >>> evr_regs.svh
// Register offsets, field positions and reset values of the event request block
`ifndef EVR_REGS_SVH
`define EVR_REGS_SVH
`define EVR_OFS_NET_MASK 16'h0200
`define EVR_OFS_HOST_MASK 16'h0204
`define EVR_OFS_NET_REQ 16'h0210
`define EVR_OFS_HOST_REQ 16'h0220
`define EVR_RST_HOST_MASK 32'h0000_0000
`define EVR_RST_NET_MASK 16'h0000
`define EVR_HB_CTRL 0
`define EVR_HB_LATCH 1
`define EVR_HB_SYNC_A 2
`define EVR_HB_SYNC_B 3
`define EVR_HB_ACT 4
`define EVR_HB_MEM 5
`define EVR_HB_WDOG 6
`define EVR_NB_LATCH 0
`define EVR_NB_LINK 2
`define EVR_NB_APP 3
`define EVR_HOST_FLAGS 7
`define EVR_NET_FLAGS 4
`endif

// >>> evr_pkg.sv
// Types shared by the event request block
`default_nettype none
package evr_pkg;
  typedef struct packed {
    logic [31:0] host_mask;
    logic [15:0] net_mask;
    logic host_irq;
    logic [15:0] net_field;
    logic [31:0] host_rdata;
    logic [15:0] net_rdata;
  } evr_state_t;
endpackage
`default_nettype wire

// >>> evr_flag_if.sv
// Set, clear and state lines of a sticky flag bank
`timescale 1ns/100ps
`default_nettype none
interface evr_flag_if #(parameter int W = 8);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] q;
  modport owner(output set, output clr, input q);
  modport bank(input set, input clr, output q);
endinterface
`default_nettype wire

// >>> evr_flag_bank.sv
// Sticky event flags where a set beats a clear in the same cycle
`timescale 1ns/100ps
`default_nettype none
module evr_flag_bank #(
  parameter int W = 8
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  evr_flag_if.bank flags
);
  typedef struct packed {
    logic [W-1:0] q;
  } evr_bank_t;
  evr_bank_t st_ff;
  evr_bank_t nxt_st;

  // Set wins so no event is lost
  always_comb begin
    nxt_st = st_ff;
    nxt_st.q = (st_ff.q & ~flags.clr) | flags.set;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign flags.q = st_ff.q;

  a_set_wins_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (|flags.set) |=> ((flags.q & $past(flags.set)) == $past(flags.set)))
    else $error("Flag set lost");
  a_clear_drops_flag: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (|(flags.clr & ~flags.set)) |=> ((flags.q & $past(flags.clr) & ~$past(flags.set)) == '0))
    else $error("Flag not cleared");
endmodule
`default_nettype wire

// >>> evr_event_ctrl.sv
// Network and host event request collection, masking and interrupt
`timescale 1ns/100ps
`default_nettype none
`include "evr_regs.svh"
module evr_event_ctrl
  import evr_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [15:0] host_addr_in,
  input wire logic host_rd_in,
  input wire logic host_wr_in,
  input wire logic [31:0] host_wdata_in,
  output logic [31:0] host_rdata_out,
  input wire logic [15:0] net_addr_in,
  input wire logic net_rd_in,
  input wire logic net_wr_in,
  input wire logic [15:0] net_wdata_in,
  output logic [15:0] net_rdata_out,
  input wire logic latch_change_in,
  input wire logic latch_host_ctrl_in,
  input wire logic net_latch_read_in,
  input wire logic host_latch_read_in,
  input wire logic link_status_change_in,
  input wire logic net_link_status_read_in,
  input wire logic app_status_change_in,
  input wire logic net_app_status_read_in,
  input wire logic [7:0] buf_pending_in,
  input wire logic app_ctrl_written_in,
  input wire logic emulation_on_in,
  input wire logic host_app_ctrl_read_in,
  input wire logic map_sync_first_in,
  input wire logic map_sync_second_in,
  input wire logic sync_pulse_first_in,
  input wire logic sync_pulse_second_in,
  input wire logic host_sync_first_read_in,
  input wire logic host_sync_second_read_in,
  input wire logic activation_change_in,
  input wire logic host_activation_read_in,
  input wire logic mem_cmd_pending_in,
  input wire logic host_mem_ack_in,
  input wire logic wdog_expired_in,
  input wire logic host_wdog_read_in,
  input wire logic [31:0] buf_irq_reg_in,
  output logic host_irq_out,
  output logic [15:0] net_event_field_out
);
  evr_state_t st_ff;
  evr_state_t nxt_st;
  logic [31:0] host_req;
  logic [15:0] net_req;

  evr_flag_if #(.W(`EVR_HOST_FLAGS)) hflag();
  evr_flag_if #(.W(`EVR_NET_FLAGS)) nflag();

  evr_flag_bank #(.W(`EVR_HOST_FLAGS)) u_host_flags (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .flags(hflag)
  );
  evr_flag_bank #(.W(`EVR_NET_FLAGS)) u_net_flags (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .flags(nflag)
  );

  // Bit 0 or bit 1 of each manager interrupt register
  function automatic logic [15:0] pair_or(input logic [31:0] v);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[2*i] | v[2*i+1];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Event sources
  always_comb begin
    hflag.set = '0;
    hflag.clr = '0;
    hflag.set[`EVR_HB_CTRL] = app_ctrl_written_in & ~emulation_on_in;
    hflag.clr[`EVR_HB_CTRL] = host_app_ctrl_read_in;
    hflag.set[`EVR_HB_LATCH] = latch_change_in & latch_host_ctrl_in;
    hflag.clr[`EVR_HB_LATCH] = host_latch_read_in;
    hflag.set[`EVR_HB_SYNC_A] = sync_pulse_first_in & map_sync_first_in;
    hflag.clr[`EVR_HB_SYNC_A] = host_sync_first_read_in | ~map_sync_first_in;
    hflag.set[`EVR_HB_SYNC_B] = sync_pulse_second_in & map_sync_second_in;
    hflag.clr[`EVR_HB_SYNC_B] = host_sync_second_read_in | ~map_sync_second_in;
    hflag.set[`EVR_HB_ACT] = activation_change_in;
    hflag.clr[`EVR_HB_ACT] = host_activation_read_in;
    hflag.set[`EVR_HB_MEM] = mem_cmd_pending_in;
    hflag.clr[`EVR_HB_MEM] = host_mem_ack_in;
    hflag.set[`EVR_HB_WDOG] = wdog_expired_in;
    hflag.clr[`EVR_HB_WDOG] = host_wdog_read_in;
  end

  always_comb begin
    nflag.set = '0;
    nflag.clr = '0;
    nflag.set[`EVR_NB_LATCH] = latch_change_in;
    nflag.clr[`EVR_NB_LATCH] = net_latch_read_in;
    nflag.set[`EVR_NB_LINK] = link_status_change_in;
    nflag.clr[`EVR_NB_LINK] = net_link_status_read_in;
    nflag.set[`EVR_NB_APP] = app_status_change_in;
    nflag.clr[`EVR_NB_APP] = net_app_status_read_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request words
  always_comb begin
    host_req = {8'h00, pair_or(buf_irq_reg_in), 1'b0, hflag.q};
    // Channel pending mirror, reserved top nibble
    net_req = {4'h0, buf_pending_in, nflag.q[3:2], 1'b0, nflag.q[0]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and outputs
  always_comb begin
    nxt_st = st_ff;
    if (host_wr_in && host_addr_in == `EVR_OFS_HOST_MASK) begin
      nxt_st.host_mask = host_wdata_in;
    end
    if (net_wr_in && net_addr_in == `EVR_OFS_NET_MASK) begin
      nxt_st.net_mask = net_wdata_in;
    end
    // Unmapped reads answer zero
    nxt_st.host_rdata = 32'h0000_0000;
    if (host_rd_in) begin
      case (host_addr_in)
        `EVR_OFS_HOST_MASK: nxt_st.host_rdata = st_ff.host_mask;
        `EVR_OFS_HOST_REQ: nxt_st.host_rdata = host_req;
        `EVR_OFS_NET_REQ: nxt_st.host_rdata = {16'h0000, net_req};
        `EVR_OFS_NET_MASK: nxt_st.host_rdata = {16'h0000, st_ff.net_mask};
        default: nxt_st.host_rdata = 32'h0000_0000;
      endcase
    end
    nxt_st.net_rdata = 16'h0000;
    if (net_rd_in) begin
      case (net_addr_in)
        `EVR_OFS_NET_MASK: nxt_st.net_rdata = st_ff.net_mask;
        `EVR_OFS_NET_REQ: nxt_st.net_rdata = net_req;
        `EVR_OFS_HOST_MASK: nxt_st.net_rdata = st_ff.host_mask[15:0];
        `EVR_OFS_HOST_REQ: nxt_st.net_rdata = host_req[15:0];
        default: nxt_st.net_rdata = 16'h0000;
      endcase
    end
    // Interrupt from masked requests, one cycle of register lag
    nxt_st.host_irq = |(host_req & st_ff.host_mask);
    nxt_st.net_field = net_req & st_ff.net_mask;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_ff.host_mask <= `EVR_RST_HOST_MASK;
      st_ff.net_mask <= `EVR_RST_NET_MASK;
      st_ff.host_irq <= 1'b0;
      st_ff.net_field <= 16'h0000;
      st_ff.host_rdata <= 32'h0000_0000;
      st_ff.net_rdata <= 16'h0000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign host_irq_out = st_ff.host_irq;
  assign net_event_field_out = st_ff.net_field;
  assign host_rdata_out = st_ff.host_rdata;
  assign net_rdata_out = st_ff.net_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_mask_write;
    host_wr_in && host_addr_in == `EVR_OFS_HOST_MASK;
  endsequence
  sequence s_mask_read;
    host_rd_in && host_addr_in == `EVR_OFS_HOST_MASK;
  endsequence

  a_mask_write_read: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_mask_write ##1 s_mask_read |=> host_rdata_out == $past(host_wdata_in, 2))
    else $error("Host mask readback wrong");
  a_irq_follows_mask: assert property (@(posedge clk_in) disable iff (!resetn_in)
    host_irq_out == |($past(host_req) & $past(st_ff.host_mask)))
    else $error("Host interrupt mismatch");
  a_net_latch_set: assert property (@(posedge clk_in) disable iff (!resetn_in)
    latch_change_in |=> net_req[`EVR_NB_LATCH])
    else $error("Network latch event missing");
  a_link_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
    net_link_status_read_in && !link_status_change_in |=> !net_req[`EVR_NB_LINK])
    else $error("Link event not cleared");
  a_app_status_set: assert property (@(posedge clk_in) disable iff (!resetn_in)
    app_status_change_in |=> net_req[`EVR_NB_APP])
    else $error("Status event missing");
  a_net_reserved_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
    net_req[15:12] == 4'h0 && net_req[11:4] == buf_pending_in)
    else $error("Network request layout wrong");
  a_ctrl_emulated: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !host_req[`EVR_HB_CTRL] && emulation_on_in |=> !host_req[`EVR_HB_CTRL])
    else $error("Control event under emulation");
  a_ctrl_set: assert property (@(posedge clk_in) disable iff (!resetn_in)
    app_ctrl_written_in && !emulation_on_in |=> host_req[`EVR_HB_CTRL])
    else $error("Control event missing");
  a_latch_host_only: assert property (@(posedge clk_in) disable iff (!resetn_in)
    latch_change_in && latch_host_ctrl_in |=> host_req[`EVR_HB_LATCH])
    else $error("Host latch event missing");
  a_sync_unmapped: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !map_sync_first_in |=> !host_req[`EVR_HB_SYNC_A])
    else $error("Unmapped first sync shown");
  a_mem_ack_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
    host_mem_ack_in && !mem_cmd_pending_in |=> !host_req[`EVR_HB_MEM])
    else $error("Memory command not acknowledged");
  a_wdog_set: assert property (@(posedge clk_in) disable iff (!resetn_in)
    wdog_expired_in |=> host_req[`EVR_HB_WDOG] [*1])
    else $error("Watchdog event missing");
  a_mgr_irq_map: assert property (@(posedge clk_in) disable iff (!resetn_in)
    host_req[23:8] == pair_or(buf_irq_reg_in) && host_req[31:24] == 8'h00)
    else $error("Manager interrupt map wrong");
  a_net_field: assert property (@(posedge clk_in) disable iff (!resetn_in)
    net_event_field_out == ($past(net_req) & $past(st_ff.net_mask)))
    else $error("Frame event field wrong");
endmodule
`default_nettype wire

// >>> evr_host_model.sv
// Host processor model driving the host register port
`timescale 1ns/100ps
`default_nettype none
module evr_host_model (
  input wire logic clk_in,
  output logic [15:0] host_addr_out,
  output logic host_rd_out,
  output logic host_wr_out,
  output logic [31:0] host_wdata_out
);
  initial begin
    host_addr_out = 16'h0000;
    host_rd_out = 1'b0;
    host_wr_out = 1'b0;
    host_wdata_out = 32'h0000_0000;
  end
  task automatic access(input logic rd, input logic [15:0] a, input logic [31:0] d);
    int idle;
    // Random idle gap so the port sees both dense and sparse traffic
    idle = $urandom_range(2, 0);
    repeat (idle) @(posedge clk_in);
    @(posedge clk_in);
    #1 host_addr_out = a;
    host_wdata_out = d;
    host_rd_out = rd;
    host_wr_out = !rd;
    @(posedge clk_in);
    #1 host_rd_out = 1'b0;
    host_wr_out = 1'b0;
    // Released bus shows inverted values, never a stale copy
    host_addr_out = ~a;
    host_wdata_out = ~d;
  endtask
endmodule
`default_nettype wire

// >>> event_request_irq_tb.sv
// Self-checking bench of the event request block
`timescale 1ns/100ps
`default_nettype none
module event_request_irq_tb;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [18:0] pls = '0;
  logic lhc = 1'b0, emu = 1'b0, map1 = 1'b0, map2 = 1'b0;
  logic [7:0] bufp = 8'h00;
  logic [31:0] bir = 32'h0000_0000, hf = 32'h0000_0000, hmask = 32'h0000_0000;
  logic [15:0] nf = 16'h0000, nmask = 16'h0000, naddr = 16'h0000, nwdata = 16'h0000;
  logic nrd = 1'b0, nwr = 1'b0, hp = 1'b0, np = 1'b0;
  logic [15:0] haddr, nrdata, nfield;
  logic hrd, hwr, irq;
  logic [31:0] hwdata, hrdata;
  logic [32:0] hq[$];
  logic [31:0] nq[$];
  int n_fail = 0, n_tests = 0, cyc = 0;
  int st[8] = '{0, 3, 5, 7, 9, 11, 13, 0};
  int cl[8] = '{1, 4, 6, 8, 10, 12, 14, 2};
  always #12.5 clk_in = ~clk_in;
  evr_host_model i_host (.clk_in(clk_in), .host_addr_out(haddr), .host_rd_out(hrd),
    .host_wr_out(hwr), .host_wdata_out(hwdata));
  evr_event_ctrl i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .host_addr_in(haddr),
    .host_rd_in(hrd), .host_wr_in(hwr), .host_wdata_in(hwdata), .host_rdata_out(hrdata),
    .net_addr_in(naddr), .net_rd_in(nrd), .net_wr_in(nwr), .net_wdata_in(nwdata),
    .net_rdata_out(nrdata), .latch_change_in(pls[0]), .latch_host_ctrl_in(lhc),
    .net_latch_read_in(pls[1]), .host_latch_read_in(pls[2]), .link_status_change_in(pls[3]),
    .net_link_status_read_in(pls[4]), .app_status_change_in(pls[5]),
    .net_app_status_read_in(pls[6]), .buf_pending_in(bufp), .app_ctrl_written_in(pls[7]),
    .emulation_on_in(emu), .host_app_ctrl_read_in(pls[8]), .map_sync_first_in(map1),
    .map_sync_second_in(map2), .sync_pulse_first_in(pls[17]), .sync_pulse_second_in(pls[18]),
    .host_sync_first_read_in(pls[15]), .host_sync_second_read_in(pls[16]),
    .activation_change_in(pls[9]), .host_activation_read_in(pls[10]),
    .mem_cmd_pending_in(pls[11]), .host_mem_ack_in(pls[12]), .wdog_expired_in(pls[13]),
    .host_wdog_read_in(pls[14]), .buf_irq_reg_in(bir), .host_irq_out(irq),
    .net_event_field_out(nfield));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] regv(input logic [15:0] a);
    logic [15:0] bm;
    for (int i = 0; i < 16; i++) bm[i] = bir[2*i] | bir[2*i+1];
    case (a)
      16'h0200: regv = {16'h0000, nmask};
      16'h0204: regv = hmask;
      16'h0210: regv = {16'h0000, nf | {4'h0, bufp, 4'h0}};
      16'h0220: regv = hf | {8'h00, bm, 8'h00};
      default: regv = 32'h0000_0000;
    endcase
  endfunction
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hread(input logic [15:0] a);
    hq.push_back({|(regv(16'h0220) & hmask), regv(a)});
    i_host.access(1'b1, a, 32'h0000_0000);
  endtask
  task automatic nread(input logic [15:0] a);
    logic [31:0] f;
    logic [31:0] v;
    f = regv(16'h0210);
    v = regv(a);
    nq.push_back({f[15:0] & nmask, v[15:0]});
    @(posedge clk_in);
    #1 naddr = a;
    nrd = 1'b1;
    @(posedge clk_in);
    #1 nrd = 1'b0;
    naddr = ~a;
  endtask
  task automatic chk_all;
    hread(16'h0220);
    nread(16'h0210);
  endtask
  task automatic pulse(input logic [18:0] m);
    @(posedge clk_in);
    #1 pls = m;
    @(posedge clk_in);
    #1 pls = '0;
    // Clears first, sets second: a set in the same cycle wins
    for (int p = 0; p < 2; p++) for (int k = 0; k < 19; k++) if (m[k]) begin
      case (k)
        0: if (p) {nf[0], hf[1]} = {1'b1, hf[1] | lhc};
        1: if (!p) nf[0] = 1'b0;
        2: if (!p) hf[1] = 1'b0;
        3: if (p) nf[2] = 1'b1;
        4: if (!p) nf[2] = 1'b0;
        5: if (p) nf[3] = 1'b1;
        6: if (!p) nf[3] = 1'b0;
        7: if (p) hf[0] = hf[0] | !emu;
        8: if (!p) hf[0] = 1'b0;
        9: if (p) hf[4] = 1'b1;
        10: if (!p) hf[4] = 1'b0;
        11: if (p) hf[5] = 1'b1;
        12: if (!p) hf[5] = 1'b0;
        13: if (p) hf[6] = 1'b1;
        14: if (!p) hf[6] = 1'b0;
        15: if (!p) hf[2] = 1'b0;
        16: if (!p) hf[3] = 1'b0;
        17: if (p) hf[2] = hf[2] | map1;
        default: if (p) hf[3] = hf[3] | map2;
      endcase
    end
    repeat (3) @(posedge clk_in);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Result watcher pairs each read answer with the oldest note
  always @(negedge clk_in) begin
    if (hp) check("host word and irq", {irq, hrdata}, hq.pop_front());
    if (np) check("net word and field", {1'b0, nfield, nrdata}, {1'b0, nq.pop_front()});
    hp <= hrd;
    np <= nrd;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude;
    end
  end
  initial begin
    void'($urandom(38831));
    repeat (16) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    foreach (st[i]) hread(16'h0200 + 16'(i) * 16'h0004);
    nread(16'h0210);
    $display("test reset done");
    hmask = $urandom();
    i_host.access(1'b0, 16'h0204, hmask);
    i_host.access(1'b0, 16'h0220, $urandom());
    hread(16'h0204);
    nmask = 16'($urandom());
    @(posedge clk_in);
    #1 {naddr, nwdata, nwr} = {16'h0200, nmask, 1'b1};
    @(posedge clk_in);
    #1 {naddr, nwdata, nwr} = {16'hfdff, ~nmask, 1'b0};
    nread(16'h0200);
    nread(16'h0204);
    $display("test masks done");
    hmask = 32'h0000_0052;
    i_host.access(1'b0, 16'h0204, hmask);
    lhc = 1'b1;
    foreach (st[i]) begin
      pulse(19'(1) << st[i]);
      chk_all;
      pulse(19'(1) << cl[i]);
      chk_all;
    end
    $display("test flags done");
    lhc = 1'b0;
    emu = 1'b1;
    pulse(19'h0_0081);
    chk_all;
    emu = 1'b0;
    // Unmapped pulses, then mapped pulses and reads
    pulse(19'h6_0000);
    chk_all;
    {map1, map2} = 2'b11;
    pulse(19'h6_0000);
    chk_all;
    pulse(19'h0_8000);
    chk_all;
    pulse(19'h1_0000);
    chk_all;
    pulse(19'h0_7800);
    chk_all;
    $display("test sources done");
    repeat (4) begin
      hmask = $urandom();
      i_host.access(1'b0, 16'h0204, hmask);
      @(posedge clk_in);
      #1 {bufp, bir} = {8'($urandom()), $urandom()};
      repeat (3) @(posedge clk_in);
      chk_all;
    end
    $display("test mirrors done");
    // Mid-run reset drops masks and flags, mirrors keep following inputs
    @(posedge clk_in);
    #1 resetn_in = 1'b0;
    {hf, nf, hmask, nmask} = '0;
    repeat (2) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    hread(16'h0204);
    nread(16'h0200);
    chk_all;
    $display("test second reset done");
    conclude;
  end
endmodule
`default_nettype wire
